/* File: dv/i2c_bus_partner.sv */
`default_nettype none
module i2c_bus_partner (
	output var i2c_event_pkg::pins_s pins
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// Remote master, 320 ns bit clock
	// ----------------------------------------
	localparam int HALF = 160;
	localparam int WAKE_NS = 100000;
	initial pins = 2'h3;
	// Odd offset keeps pin edges off the system clock edges
	task automatic start_cond();
		#7 pins.sda = 1'h0;
		#WAKE_NS pins.scl = 1'h0;
		#HALF;
	endtask : start_cond
	task automatic clocks(input int n);
		repeat (n) begin
			#HALF pins.scl = 1'h1;
			#HALF pins.scl = 1'h0;
		end
	endtask : clocks
	task automatic stop_cond();
		#7 pins.sda = 1'h0;
		#HALF pins.scl = 1'h1;
		#HALF pins.sda = 1'h1;
		#(HALF - 7);
	endtask : stop_cond
endmodule : i2c_bus_partner
`default_nettype wire

/* File: dv/i2c_event_flags_properties.sv */
`default_nettype none
module i2c_event_flags_properties (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic busBusy,
	input wire logic arbLostDetect,
	input wire logic busErrorIn,
	input wire logic standbyMode,
	input wire logic transferDone,
	input wire logic sclHoldLow,
	input wire logic busErrorReq,
	input wire logic arbLostIrq,
	input wire logic stopDetectIrq,
	input wire logic wakeIrq
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// Port relations
	// ----------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	a_hold_follows_done: assert property (sclHoldLow == transferDone)
		else $error("clock hold differs from done flag");
	// Software writes are the only way down; a write lands as bvalid rises
	a_flags_fall_write: assert property (
		$fell(arbLostIrq) || $fell(stopDetectIrq) || $fell(transferDone) |-> $rose(s_axi_bvalid))
		else $error("flag dropped without a write");
	a_arb_irq_cause: assert property (
		$rose(arbLostIrq) |-> $past(arbLostDetect) || $rose(s_axi_bvalid))
		else $error("lost request without cause");
	a_stop_irq_cause: assert property (
		$rose(stopDetectIrq) |-> $past(busBusy) || $rose(s_axi_bvalid))
		else $error("stop request without busy bus");
	a_wake_in_standby: assert property (
		$rose(wakeIrq) |-> $past(standbyMode) || $rose(s_axi_bvalid))
		else $error("wake request outside standby");
	a_error_passes: assert property (busErrorIn |=> busErrorReq)
		else $error("bus error not reported");
	a_write_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
endmodule : i2c_event_flags_properties
bind i2c_event_flags i2c_event_flags_properties i_props (.*);
`default_nettype wire

/* File: dv/i2c_event_flags_tb_top.sv */
`default_nettype none
module i2c_event_flags_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [3:0] C0 = i2c_event_pkg::ADDR_CTRL0;
	localparam logic [3:0] EV = i2c_event_pkg::ADDR_EVENTS;
	localparam logic [1:0] OK = i2c_event_pkg::RESP_OKAY;
	typedef struct packed {
		logic       en;
		logic       err;
		logic [3:0] addr;
		logic [7:0] wd;
		logic [7:0] rdExp;
		logic [1:0] resp;
	} row_s;
	localparam row_s ROWS [6] = '{
		'{1'h1, 1'h0, C0, 8'hd5, 8'hd5, OK}, '{1'h1, 1'h0, C0, 8'hff, 8'hd5, OK},
		'{1'h0, 1'h0, C0, 8'hff, 8'h14, OK}, '{1'h1, 1'h1, C0, 8'hff, 8'h14, OK},
		'{1'h1, 1'h0, 4'hc, 8'hff, 8'h00, i2c_event_pkg::RESP_SLVERR},
		'{1'h1, 1'h0, C0, 8'h00, 8'h00, OK}};
	logic clk_sys = 1'h0, arst_n = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h1;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	i2c_event_pkg::pins_s busPins;
	logic busBusy = 1'h0, masterMode = 1'h0, receiving = 1'h0, arbLostDetect = 1'h0;
	logic slaveAckSent = 1'h0, interfaceEnable = 1'h1, busErrorIn = 1'h0, standbyMode = 1'h0;
	logic transferDone, sclHoldLow, busErrorReq, arbLostIrq, stopDetectIrq, wakeIrq;
	int mismatches = 0, checksDone = 0, cycles = 0, errPulses = 0, errMark = 0;
	i2c_event_flags i_i2c_event_flags (.*);
	i2c_bus_partner i_bus (.pins(busPins));
	initial forever #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (busErrorReq === 1'h1) errPulses <= errPulses + 1;
		if (cycles == 60000) begin
			mismatches++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checksDone, mismatches);
		if (mismatches == 0 && checksDone > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [7:0] got, input logic [7:0] e);
		checksDone++;
		if (got !== e) begin
			mismatches++;
			$display("ERROR %0t got %h expected %h", $time, got, e);
		end
	endtask : chk
	task automatic fl(input logic f, input logic e);
		chk({7'h0, f}, {7'h0, e});
	endtask : fl
	task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		chk({6'h0, s_axi_bresp}, {6'h0, er});
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [1:0] er);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h0;
		chk({6'h0, s_axi_rresp}, {6'h0, er});
		if (er === OK) chk(s_axi_rdata[7:0], e);
	endtask : rd
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'h1;
		repeat (3) @(posedge clk_sys);
		rd(C0, i2c_event_pkg::CTRL0_RESET, OK);
		foreach (ROWS[i]) begin
			interfaceEnable <= ROWS[i].en;
			busErrorIn <= ROWS[i].err;
			wr(ROWS[i].addr, ROWS[i].wd, ROWS[i].resp);
			rd(ROWS[i].addr, ROWS[i].rdExp, ROWS[i].resp);
		end
		busBusy <= 1'h1;
		i_bus.start_cond();
		i_bus.clocks(8);
		repeat (8) @(posedge clk_sys);
		fl(transferDone, 1'h0);
		i_bus.clocks(1);
		repeat (8) @(posedge clk_sys);
		fl(sclHoldLow, 1'h1);
		rd(i2c_event_pkg::ADDR_STATUS, 8'h05, OK);
		wr(EV, 8'h01, OK);
		fl(transferDone, 1'h0);
		i_bus.stop_cond();
		receiving <= 1'h1;
		wr(C0, 8'h40, OK);
		i_bus.start_cond();
		i_bus.clocks(8);
		repeat (8) @(posedge clk_sys);
		fl(transferDone, 1'h1);
		wr(C0, 8'h00, OK);
		wr(EV, 8'h01, OK);
		i_bus.clocks(1);
		repeat (8) @(posedge clk_sys);
		fl(transferDone, 1'h1);
		wr(EV, 8'h01, OK);
		i_bus.stop_cond();
		masterMode <= 1'h1;
		wr(C0, 8'h10, OK);
		arbLostDetect <= 1'h1;
		@(posedge clk_sys);
		arbLostDetect <= 1'h0;
		@(posedge clk_sys);
		fl(arbLostIrq, 1'h1);
		wr(C0, 8'h10, OK);
		fl(arbLostIrq, 1'h1);
		wr(EV, 8'h04, OK);
		rd(C0, 8'h3a, OK);
		busBusy <= 1'h0;
		wr(C0, 8'h10, OK);
		fl(arbLostIrq, 1'h0);
		busBusy <= 1'h1;
		masterMode <= 1'h0;
		wr(EV, 8'h02, OK);
		fl(arbLostIrq, 1'h1);
		wr(EV, 8'h01, OK);
		fl(arbLostIrq, 1'h0);
		slaveAckSent <= 1'h1;
		wr(EV, 8'h02, OK);
		fl(arbLostIrq, 1'h0);
		wr(C0, 8'h04, OK);
		i_bus.start_cond();
		i_bus.stop_cond();
		repeat (8) @(posedge clk_sys);
		fl(stopDetectIrq, 1'h1);
		busBusy <= 1'h0;
		wr(C0, 8'h01, OK);
		fl(stopDetectIrq, 1'h0);
		i_bus.start_cond();
		repeat (8) @(posedge clk_sys);
		fl(wakeIrq, 1'h0);
		errMark = errPulses;
		standbyMode <= 1'h1;
		i_bus.stop_cond();
		i_bus.start_cond();
		repeat (8) @(posedge clk_sys);
		fl(wakeIrq, 1'h1);
		fl(errPulses != errMark, 1'h0);
		standbyMode <= 1'h0;
		busBusy <= 1'h1;
		wr(C0, 8'h00, OK);
		errMark = errPulses;
		standbyMode <= 1'h1;
		i_bus.stop_cond();
		i_bus.start_cond();
		repeat (8) @(posedge clk_sys);
		fl(errPulses != errMark, 1'h1);
		arst_n <= 1'h0;
		@(posedge clk_sys);
		fl(busErrorReq, 1'h0);
		arst_n <= 1'h1;
		rd(C0, i2c_event_pkg::CTRL0_RESET, OK);
		give_verdict();
	end
endmodule : i2c_event_flags_tb_top
`default_nettype wire

/* File: logic/i2c_event_flags.sv */
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`default_nettype none
// What this block does
// - Set done flag at clock eight or nine
// - Arbitration loss as master sets lost flag
// - Master select on busy bus sets lost
// - Lost cleared by zero-write when idle
// - Write zero clears flags; RMW reads one
// - Lost interrupt equals flag and enable
// - Valid STOP on busy bus sets flag
// - STOP interrupt equals flag and enable
// - START with wake enabled sets wake flag
// - Wake request when flag and enable
// - Wakeup acts only in stop or watch
// - Standby holds state; bus idle first
// - Standby entered busy gives error on START
// - Disabled or error forces three bits zero
// - Clearing done flag releases clock line
module i2c_event_flags (
	input  wire logic                 clk_sys,
	input  wire logic                 arst_n,
	input  wire logic [3:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [3:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire i2c_event_pkg::pins_s busPins,
	input  wire logic                 busBusy,
	input  wire logic                 masterMode,
	input  wire logic                 receiving,
	input  wire logic                 arbLostDetect,
	input  wire logic                 slaveAckSent,
	input  wire logic                 interfaceEnable,
	input  wire logic                 busErrorIn,
	input  wire logic                 standbyMode,
	output logic                      transferDone,
	output logic                      sclHoldLow,
	output logic                      busErrorReq,
	output logic                      arbLostIrq,
	output logic                      stopDetectIrq,
	output logic                      wakeIrq
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0]            sclSync;
		logic [2:0]            sdaSync;
		logic                  sclQ;
		logic                  sdaQ;
		logic [3:0]            bitCnt;
		logic                  inFrame;
		i2c_event_pkg::ctrl0_s ctrl;
		logic                  tdone;
		logic                  ackSentSeen;
		logic                  busyAtStandby;
		logic                  berr;
		logic                  rmwNext;
		logic                  awHave;
		logic [3:0]            awAddr;
		logic                  wHave;
		logic [31:0]           wData;
		logic [3:0]            wStrb;
		logic                  bValid;
		logic [1:0]            bResp;
		logic                  rValid;
		logic [31:0]           rData;
		logic [1:0]            rResp;
	} state_s;

	state_s st_reg;
	state_s st_next;

	logic sclNow;
	logic sdaNow;
	logic sclRise;
	logic sclFall;
	logic startCond;
	logic stopCond;
	logic wrFire;
	logic wrCtrl;
	logic wrEvt;
	logic tdoneClear;
	logic mssWrite;
	logic forceZero;
	logic [7:0] ctrlRead;

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	// The control byte is read back whole into the low data byte
	if ($bits(i2c_event_pkg::ctrl0_s) != 8) begin : g_ctrl_width
		$error("control byte is not eight bits");
	end
	// The eighth-clock compare looks one count below the eighth
	if (i2c_event_pkg::CNT_EIGHTH == 4'h0) begin : g_eighth_nonzero
		$error("eighth clock count must not be zero");
	end
	if (i2c_event_pkg::CNT_NINTH != i2c_event_pkg::CNT_EIGHTH + 4'h1) begin : g_ninth_follows
		$error("ninth clock count must follow the eighth");
	end
	// Bit count field must sit inside the returned status byte
	if (i2c_event_pkg::ST_BITCNT + 4 > 8) begin : g_status_fit
		$error("bit count does not fit the status byte");
	end
	// Register decode needs three distinct word addresses
	if (i2c_event_pkg::ADDR_CTRL0 == i2c_event_pkg::ADDR_EVENTS
			|| i2c_event_pkg::ADDR_EVENTS == i2c_event_pkg::ADDR_STATUS
			|| i2c_event_pkg::ADDR_CTRL0 == i2c_event_pkg::ADDR_STATUS) begin : g_addr_distinct
		$error("register addresses overlap");
	end

	always_comb begin
		// --------------------------------------------------------
		// Pin sampling: second and third stages must agree
		// --------------------------------------------------------
		sclNow = (st_reg.sclSync[2] == st_reg.sclSync[1]) ? st_reg.sclSync[1] : st_reg.sclQ;
		sdaNow = (st_reg.sdaSync[2] == st_reg.sdaSync[1]) ? st_reg.sdaSync[1] : st_reg.sdaQ;
		sclRise   = sclNow & ~st_reg.sclQ;
		sclFall   = ~sclNow & st_reg.sclQ;
		startCond = sclNow & st_reg.sclQ & st_reg.sdaQ & ~sdaNow;
		stopCond  = sclNow & st_reg.sclQ & ~st_reg.sdaQ & sdaNow;

		wrFire = st_reg.awHave & st_reg.wHave & ~st_reg.bValid;
		wrCtrl = wrFire & (st_reg.awAddr == i2c_event_pkg::ADDR_CTRL0) & st_reg.wStrb[0];
		wrEvt  = wrFire & (st_reg.awAddr == i2c_event_pkg::ADDR_EVENTS) & st_reg.wStrb[0];
		tdoneClear = wrEvt & st_reg.wData[i2c_event_pkg::EVT_TDONE_CLR];
		mssWrite   = wrEvt & st_reg.wData[i2c_event_pkg::EVT_MSS_SET];
		forceZero  = ~interfaceEnable | st_reg.berr;

		st_next = st_reg;
		// --------------------------------------------------------
		// Pin stages and level history
		// --------------------------------------------------------
		st_next.sclSync = {st_reg.sclSync[1:0], busPins.scl};
		st_next.sdaSync = {st_reg.sdaSync[1:0], busPins.sda};
		st_next.sclQ = sclNow;
		st_next.sdaQ = sdaNow;

		// --------------------------------------------------------
		// Bit counting within a byte
		// --------------------------------------------------------
		if (startCond) begin
			st_next.bitCnt  = 4'h0;
			st_next.inFrame = 1'b1;
		end else if (stopCond) begin
			st_next.inFrame = 1'b0;
		end else if (sclRise && st_reg.inFrame && !st_reg.tdone) begin
			st_next.bitCnt = (st_reg.bitCnt == i2c_event_pkg::CNT_NINTH) ? 4'h1
				: st_reg.bitCnt + 4'h1;
		end
		// Restart count on the byte after a completed one
		if (sclFall && st_reg.bitCnt == i2c_event_pkg::CNT_NINTH)
			st_next.bitCnt = 4'h0;

		// --------------------------------------------------------
		// Transfer-done flag
		// --------------------------------------------------------
		// Eighth-clock timing only while receiving data
		if (sclRise && st_reg.inFrame && !standbyMode) begin
			if (st_reg.bitCnt == i2c_event_pkg::CNT_EIGHTH - 4'h1 && receiving
					&& st_reg.ctrl.intTimingSel)
				st_next.tdone = 1'b1;
			else if (st_reg.bitCnt == i2c_event_pkg::CNT_EIGHTH)
				st_next.tdone = 1'b1;
		end
		if (tdoneClear && !(st_next.tdone && !st_reg.tdone))
			st_next.tdone = 1'b0;

		// --------------------------------------------------------
		// bus_control_zero writes and flags
		// --------------------------------------------------------
		if (wrCtrl) begin
			st_next.ctrl.ackDisable      = st_reg.wData[i2c_event_pkg::BIT_ACKDIS];
			st_next.ctrl.intTimingSel    = st_reg.wData[i2c_event_pkg::BIT_INT_TIMING_SEL];
			st_next.ctrl.arbLostIrqEn    = st_reg.wData[i2c_event_pkg::BIT_ALE];
			st_next.ctrl.stopDetectIrqEn = st_reg.wData[i2c_event_pkg::BIT_SPE];
			st_next.ctrl.wakeEnable      = st_reg.wData[i2c_event_pkg::BIT_WUE];
			if (!st_reg.wData[i2c_event_pkg::BIT_ALF] && !busBusy)
				st_next.ctrl.arbLostFlag = 1'b0;
			if (!st_reg.wData[i2c_event_pkg::BIT_SPF])
				st_next.ctrl.stopDetectFlag = 1'b0;
			if (!st_reg.wData[i2c_event_pkg::BIT_WUF])
				st_next.ctrl.wakeFlag = 1'b0;
		end
		if (tdoneClear)
			st_next.ctrl.arbLostFlag = 1'b0;

		// --------------------------------------------------------
		// Event flag sets
		// --------------------------------------------------------
		// Sets come last so they beat a simultaneous clear
		// Slave acknowledge counts until the bus goes idle
		if (slaveAckSent)
			st_next.ackSentSeen = 1'b1;
		else if (!busBusy)
			st_next.ackSentSeen = 1'b0;
		if (arbLostDetect && masterMode)
			st_next.ctrl.arbLostFlag = 1'b1;
		if (mssWrite && busBusy && !masterMode && !st_reg.ackSentSeen)
			st_next.ctrl.arbLostFlag = 1'b1;
		if (stopCond && busBusy && !standbyMode)
			st_next.ctrl.stopDetectFlag = 1'b1;
		if (startCond && st_reg.ctrl.wakeEnable && standbyMode)
			st_next.ctrl.wakeFlag = 1'b1;

		// --------------------------------------------------------
		// Standby and bus error
		// --------------------------------------------------------
		// Standby entered with the bus busy is remembered
		// Error request is a one-cycle pulse unless the external flag holds it
		if (!standbyMode)
			st_next.busyAtStandby = busBusy;
		if (startCond && standbyMode && st_reg.busyAtStandby)
			st_next.berr = 1'b1;
		else if (!busErrorIn)
			st_next.berr = 1'b0;
		if (busErrorIn)
			st_next.berr = 1'b1;

		// --------------------------------------------------------
		// Bits forced while off or in error
		// --------------------------------------------------------
		if (forceZero) begin
			st_next.ctrl.ackDisable   = 1'b0;
			st_next.ctrl.intTimingSel = 1'b0;
			st_next.ctrl.wakeEnable   = 1'b0;
		end

		// --------------------------------------------------------
		// AXI4-Lite slave
		// --------------------------------------------------------
		if (s_axi_awvalid && !st_reg.awHave) begin
			st_next.awHave = 1'b1;
			st_next.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_reg.wHave) begin
			st_next.wHave = 1'b1;
			st_next.wData = s_axi_wdata;
			st_next.wStrb = s_axi_wstrb;
		end
		if (wrFire) begin
			st_next.awHave = 1'b0;
			st_next.wHave  = 1'b0;
			st_next.bValid = 1'b1;
			st_next.bResp  = (st_reg.awAddr == i2c_event_pkg::ADDR_CTRL0
				|| st_reg.awAddr == i2c_event_pkg::ADDR_EVENTS)
				? i2c_event_pkg::RESP_OKAY : i2c_event_pkg::RESP_SLVERR;
			if (wrEvt)
				st_next.rmwNext = st_reg.wData[i2c_event_pkg::EVT_RMW_READ];
		end
		if (st_reg.bValid && s_axi_bready)
			st_next.bValid = 1'b0;

		// --------------------------------------------------------
		// Read channel
		// --------------------------------------------------------
		// Flags read as one when a read-modify-write is armed
		ctrlRead = st_reg.ctrl;
		if (st_reg.rmwNext) begin
			ctrlRead[i2c_event_pkg::BIT_ALF] = 1'b1;
			ctrlRead[i2c_event_pkg::BIT_SPF] = 1'b1;
			ctrlRead[i2c_event_pkg::BIT_WUF] = 1'b1;
		end
		if (s_axi_arvalid && !st_reg.rValid) begin
			st_next.rValid = 1'b1;
			st_next.rResp  = i2c_event_pkg::RESP_OKAY;
			st_next.rData  = 32'h0;
			unique case (s_axi_araddr)
				i2c_event_pkg::ADDR_CTRL0: begin
					st_next.rData[7:0] = ctrlRead;
					st_next.rmwNext    = 1'b0;
				end
				i2c_event_pkg::ADDR_EVENTS: begin
					st_next.rData[i2c_event_pkg::EVT_RMW_READ] = st_reg.rmwNext;
				end
				i2c_event_pkg::ADDR_STATUS: begin
					st_next.rData[i2c_event_pkg::ST_TDONE]   = st_reg.tdone;
					st_next.rData[i2c_event_pkg::ST_BERR]    = st_reg.berr;
					st_next.rData[i2c_event_pkg::ST_SCLHOLD] = st_reg.tdone;
					st_next.rData[i2c_event_pkg::ST_BITCNT +: 4] = st_reg.bitCnt;
				end
				default: st_next.rResp = i2c_event_pkg::RESP_SLVERR;
			endcase
		end
		if (st_reg.rValid && s_axi_rready)
			st_next.rValid = 1'b0;
	end

	// Pin stages reset to the idle-high bus level: no false edge after reset
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_reg         <= '0;
			st_reg.sclSync <= 3'h7;
			st_reg.sdaSync <= 3'h7;
			st_reg.sclQ    <= 1'b1;
			st_reg.sdaQ    <= 1'b1;
			st_reg.ctrl    <= i2c_event_pkg::CTRL0_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign s_axi_awready = ~st_reg.awHave;
	assign s_axi_wready  = ~st_reg.wHave;
	assign s_axi_bvalid  = st_reg.bValid;
	assign s_axi_bresp   = st_reg.bResp;
	assign s_axi_arready = ~st_reg.rValid;
	assign s_axi_rvalid  = st_reg.rValid;
	assign s_axi_rdata   = st_reg.rData;
	assign s_axi_rresp   = st_reg.rResp;
	assign transferDone  = st_reg.tdone;
	// Pin driver sits outside; the line stays held while done stands
	assign sclHoldLow    = st_reg.tdone;
	assign busErrorReq   = st_reg.berr;
	assign arbLostIrq    = st_reg.ctrl.arbLostFlag & st_reg.ctrl.arbLostIrqEn;
	assign stopDetectIrq = st_reg.ctrl.stopDetectFlag & st_reg.ctrl.stopDetectIrqEn;
	assign wakeIrq       = st_reg.ctrl.wakeFlag & st_reg.ctrl.wakeEnable;
endmodule : i2c_event_flags
`default_nettype wire

/* File: logic/i2c_event_pkg.sv */
`default_nettype none
package i2c_event_pkg;
	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_CTRL0  = 4'h0;
	localparam logic [3:0] ADDR_EVENTS = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	// ------------------------------------------------------------
	// bus_control_zero fields
	// ------------------------------------------------------------
	localparam int BIT_ACKDIS  = 7;
	localparam int BIT_INT_TIMING_SEL    = 6;
	localparam int BIT_ALF     = 5;
	localparam int BIT_ALE     = 4;
	localparam int BIT_SPF     = 3;
	localparam int BIT_SPE     = 2;
	localparam int BIT_WUF     = 1;
	localparam int BIT_WUE     = 0;
	localparam logic [7:0] CTRL0_RESET = 8'h00;
	// Events register: bits 0-1 write 1 pulses, bit 2 arms the RMW read; bit positions
	localparam int EVT_TDONE_CLR = 0;
	localparam int EVT_MSS_SET   = 1;
	localparam int EVT_RMW_READ  = 2;
	// Status register fields
	localparam int ST_TDONE   = 0;
	localparam int ST_BERR    = 1;
	localparam int ST_SCLHOLD = 2;
	localparam int ST_BITCNT  = 4;
	// ------------------------------------------------------------
	// AXI responses
	// ------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Clocks of a byte
	localparam logic [3:0] CNT_EIGHTH = 4'h8;
	localparam logic [3:0] CNT_NINTH  = 4'h9;

	typedef struct packed {
		logic scl;
		logic sda;
	} pins_s;

	typedef struct packed {
		logic ackDisable;
		logic intTimingSel;
		logic arbLostFlag;
		logic arbLostIrqEn;
		logic stopDetectFlag;
		logic stopDetectIrqEn;
		logic wakeFlag;
		logic wakeEnable;
	} ctrl0_s;
endpackage : i2c_event_pkg
`default_nettype wire
